// *** design/uart_async_pkg.sv ***
// Purpose: constants, register map and types for the async serial channel
// Assumes: one register per index, up to 16 bits wide, on a plain strobe port
// Notes: rx buffer and control flags are packed at the listed bit positions
package uart_async_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_TXBUF = 4'h0; // transmit buffer, write only
  localparam logic [3:0] OFS_RXBUF = 4'h1; // receive buffer and errors
  localparam logic [3:0] OFS_DIV = 4'h2; // baud divider, write only
  localparam logic [3:0] OFS_MODE = 4'h3; // serial mode config
  localparam logic [3:0] OFS_CTRL0 = 4'h4; // serial control 0
  localparam logic [3:0] OFS_CTRL1 = 4'h5; // serial control 1
  localparam logic [3:0] OFS_SHARED = 4'h6; // shared serial control

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int RX_OVR_BIT = 12; // overrun flag in rx buffer word
  localparam int RX_FRM_BIT = 13; // framing flag
  localparam int RX_PAR_BIT = 14; // parity flag
  localparam int RX_SUM_BIT = 15; // error summary flag
  localparam int SHARED_SPLIT_BIT = 6; // split handshake select
  localparam logic [2:0] SMD_7BIT = 3'h4; // async, seven data bits
  localparam logic [2:0] SMD_8BIT = 3'h5; // async, eight data bits
  localparam logic [2:0] SMD_9BIT = 3'h6; // async, nine data bits
  localparam logic [1:0] SRC_DIV1 = 2'h0; // count source undivided
  localparam logic [1:0] SRC_DIV2 = 2'h1; // count source by two
  localparam logic [1:0] SRC_DIV8 = 2'h2; // count source by eight
  localparam logic [1:0] SRC_DIV32 = 2'h3; // count source by thirty-two

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00; // mode config after reset
  localparam logic [7:0] CTRL0_RST = 8'h10; // handshake disabled
  localparam logic [7:0] CTRL1_RST = 8'h00; // tx and rx disabled
  localparam logic [7:0] DIV_RST = 8'h00; // divider after reset
  localparam logic [3:0] TICK_LAST = 4'hF; // sixteen ticks per bit
  localparam logic [3:0] TICK_MID = 4'h7; // mid-bit sample point

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pol; // pin polarity invert
    logic pe; // parity enable
    logic even; // parity odd even select, 1 = even
    logic stp; // stop length select, 1 = two stop bits
    logic clock_source_direction; // clock source direction, 1 = external
    logic [2:0] smd; // serial mode select
  } mode_cfg_t;

  typedef struct packed {
    logic order; // bit order select, 1 = msb first, eight-bit mode only
    logic edge_pol; // clock edge polarity, unused here
    logic od; // tx open drain select
    logic dis; // handshake disable
    logic tx_shift_empty_flag; // tx shift empty flag, read only
    logic dir; // handshake direction select, 1 = rts
    logic [1:0] src; // divider source select
  } ctrl0_t;

  typedef struct packed {
    logic spare7; // kept as stored
    logic inv; // data logic invert
    logic err_sig; // error signal enable, unused here
    logic irs; // tx irq source select
    logic ri; // rx complete flag, read only
    logic re; // rx enable bit
    logic ti; // tx buffer empty flag, read only
    logic te; // tx enable bit
  } ctrl1_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'h0,
    T_START = 3'h1,
    T_DATA = 3'h3,
    T_PAR = 3'h2,
    T_STOP = 3'h6
  } tx_state_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'h0,
    R_START = 3'h1,
    R_DATA = 3'h3,
    R_PAR = 3'h2,
    R_STOP = 3'h6
  } rx_state_t;

endpackage

// *** design/uart_async_channel.sv ***
// Purpose: one asynchronous serial channel with registers and handshake
// Assumes: pins are asynchronous to clk; register port on clk
// Notes: baud tick is sixteen times the bit rate
`timescale 1ns/1ns
module uart_async_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic serial_in_pin,
  input wire logic serial_clock_pin,
  input wire logic handshake_in,
  input wire logic peer_handshake_in,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic handshake_out,
  output logic handshake_oe,
  output logic tx_irq,
  output logic rx_irq
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  uart_async_pkg::mode_cfg_t mode; // serial mode config
  uart_async_pkg::ctrl0_t c0; // control 0, stored bits
  uart_async_pkg::ctrl1_t c1; // control 1, stored bits
  uart_async_pkg::tx_state_t tst; // transmit state
  uart_async_pkg::rx_state_t rst_q; // receive state
  logic split; // split handshake select
  logic [7:0] div_n; // baud divider
  logic [8:0] tbuf; // transmit buffer
  logic tbuf_empty; // tx buffer empty flag
  logic [8:0] rbuf; // receive buffer
  logic rx_full; // rx complete flag
  logic ovr, framing_flag, parity_flag; // error flags
  logic [4:0] pre; // prescaler
  logic [7:0] dcnt; // divider counter
  logic tick; // sixteen-per-bit tick
  logic rx_s1, rx_s2, ck_s1, ck_s2, ck_s3; // pin synchronisers
  logic cts_s1, cts_s2, pcts_s1, pcts_s2; // handshake synchronisers
  logic rx_prev; // previous rx level
  logic [3:0] tcnt, tbit, rcnt, rbit; // tick and bit counters
  logic [8:0] tsh, rsh; // shift registers
  logic tpar, racc, rbad, rfer, rovr; // parity and frame state

  // ----------------------------------------------------------------
  // decode and datapath helpers
  // ----------------------------------------------------------------
  logic async_mode, tx_wr, rx_rd, src_en, ext_edge, rx_level;
  logic [3:0] nbits;
  logic [8:0] dmask, raw_tx, txd, rx_al, rx_word;
  logic [7:0] rev_tx, rev_rx;
  logic cts_used, cts_ok, tx_go, tx_line, tend, sample, rend, done;
  logic ovr_pt;
  logic [15:0] next_rdata;

  assign tx_wr = wr_stb && (addr == uart_async_pkg::OFS_TXBUF);
  assign rx_rd = rd_stb && (addr == uart_async_pkg::OFS_RXBUF);
  // only the three async codes run the channel
  assign async_mode = (mode.smd == uart_async_pkg::SMD_7BIT)
    || (mode.smd == uart_async_pkg::SMD_8BIT)
    || (mode.smd == uart_async_pkg::SMD_9BIT);
  // character length from mode code
  assign nbits = (mode.smd == uart_async_pkg::SMD_7BIT) ? 4'h7 :
    (mode.smd == uart_async_pkg::SMD_8BIT) ? 4'h8 : 4'h9;
  assign dmask = (nbits == 4'h7) ? 9'h07F :
    (nbits == 4'h8) ? 9'h0FF : 9'h1FF;

  // bit reversal for msb-first eight-bit characters
  assign raw_tx = (tbuf ^ (c1.inv ? dmask : 9'h000)) & dmask;
  for (genvar g = 0; g < 8; g++) begin : g_rev
    assign rev_tx[g] = raw_tx[7 - g];
    assign rev_rx[g] = rsh[8 - g];
  end
  assign txd = (nbits == 4'h8 && c0.order) ? {1'b0, rev_tx} : raw_tx;
  // align received bits down from the top of the shifter
  assign rx_al = (nbits == 4'h9) ? rsh :
    (nbits == 4'h8) ? (c0.order ? {1'b0, rev_rx} : {1'b0, rsh[8:1]}) :
    {2'b00, rsh[8:2]};
  assign rx_word = (rbuf ^ (c1.inv ? dmask : 9'h000)) & dmask;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops on every pin, third only for edge detect
  always_ff @(posedge clk) begin
    rx_s1 <= serial_in_pin;
    rx_s2 <= rx_s1;
    ck_s1 <= serial_clock_pin;
    ck_s2 <= ck_s1;
    ck_s3 <= ck_s2;
    cts_s1 <= handshake_in;
    cts_s2 <= cts_s1;
    pcts_s1 <= peer_handshake_in;
    pcts_s2 <= pcts_s1;
  end

  assign rx_level = rx_s2 ^ mode.pol;
  assign ext_edge = ck_s2 && !ck_s3;

  // ----------------------------------------------------------------
  // baud generation
  // ----------------------------------------------------------------
  // free prescaler feeding the source select
  always_ff @(posedge clk) begin
    if (rst) begin
      pre <= 5'h00;
    end else begin
      pre <= pre + 5'h01;
    end
  end

  always_comb begin
    if (mode.clock_source_direction) begin
      src_en = ext_edge;
    end else begin
      unique case (c0.src)
        uart_async_pkg::SRC_DIV1: src_en = 1'b1;
        uart_async_pkg::SRC_DIV2: src_en = pre[0];
        uart_async_pkg::SRC_DIV8: src_en = &pre[2:0];
        uart_async_pkg::SRC_DIV32: src_en = &pre;
      endcase
    end
  end

  // divide source by n+1 to get the tick
  always_ff @(posedge clk) begin
    if (rst) begin
      dcnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (src_en) begin
        if (dcnt == 8'h00) begin
          dcnt <= div_n;
          tick <= 1'b1;
        end else begin
          dcnt <= dcnt - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= uart_async_pkg::MODE_RST;
      c0 <= uart_async_pkg::CTRL0_RST;
      c1 <= uart_async_pkg::CTRL1_RST;
      div_n <= uart_async_pkg::DIV_RST;
      split <= 1'b0;
    end else if (wr_stb) begin
      unique case (addr)
        uart_async_pkg::OFS_MODE: mode <= wdata[7:0];
        uart_async_pkg::OFS_CTRL0: c0 <= wdata[7:0];
        uart_async_pkg::OFS_CTRL1: c1 <= wdata[7:0];
        uart_async_pkg::OFS_DIV: div_n <= wdata[7:0];
        uart_async_pkg::OFS_SHARED:
          split <= wdata[uart_async_pkg::SHARED_SPLIT_BIT];
        default: ; // other indices ignore writes
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // cts from own pin, or from the peer pin when split
  assign cts_used = !c0.dis && (!c0.dir || split);
  assign cts_ok = !cts_used
    || !(split ? pcts_s2 : cts_s2);
  // a write in the same cycle defers the load
  assign tx_go = (tst == uart_async_pkg::T_IDLE) && async_mode && c1.te
    && !tbuf_empty && cts_ok && !tx_wr;
  assign tend = tick && (tcnt == uart_async_pkg::TICK_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      tst <= uart_async_pkg::T_IDLE;
      tcnt <= 4'h0;
      tbit <= 4'h0;
      tsh <= 9'h000;
      tpar <= 1'b0;
    end else begin
      if (tst != uart_async_pkg::T_IDLE && tick) begin
        tcnt <= tcnt + 4'h1;
      end
      unique case (tst)
        uart_async_pkg::T_IDLE: if (tx_go) begin
          tsh <= txd;
          tpar <= ^txd ^ !mode.even;
          tcnt <= 4'h0;
          tbit <= 4'h0;
          tst <= uart_async_pkg::T_START;
        end
        uart_async_pkg::T_START: if (tend) begin
          tst <= uart_async_pkg::T_DATA;
        end
        uart_async_pkg::T_DATA: if (tend) begin
          tsh <= {1'b0, tsh[8:1]};
          if (tbit == nbits - 4'h1) begin
            tbit <= 4'h0;
            tst <= mode.pe ? uart_async_pkg::T_PAR
              : uart_async_pkg::T_STOP;
          end else begin
            tbit <= tbit + 4'h1;
          end
        end
        uart_async_pkg::T_PAR: if (tend) begin
          tst <= uart_async_pkg::T_STOP;
        end
        uart_async_pkg::T_STOP: if (tend) begin
          if (tbit[0] == mode.stp) begin
            tst <= uart_async_pkg::T_IDLE;
          end else begin
            tbit <= tbit + 4'h1;
          end
        end
        default: tst <= uart_async_pkg::T_IDLE; // illegal code
      endcase
    end
  end

  // line level before pin inversion
  always_comb begin
    unique case (tst)
      uart_async_pkg::T_START: tx_line = 1'b0;
      uart_async_pkg::T_DATA: tx_line = tsh[0];
      uart_async_pkg::T_PAR: tx_line = tpar;
      default: tx_line = 1'b1; // idle and stop
    endcase
  end

  // transmit buffer empty flag
  always_ff @(posedge clk) begin
    if (rst) begin
      tbuf <= 9'h000;
      tbuf_empty <= 1'b1;
    end else if (tx_wr) begin
      tbuf <= wdata[8:0];
      tbuf_empty <= 1'b0;
    end else if (tx_go) begin
      tbuf_empty <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign sample = tick && (rcnt == uart_async_pkg::TICK_MID);
  assign rend = tick && (rcnt == uart_async_pkg::TICK_LAST);
  assign done = sample && (rst_q == uart_async_pkg::R_STOP)
    && (rbit[0] == mode.stp);
  // the bit just before the last stop bit
  assign ovr_pt = sample && (
    (rst_q == uart_async_pkg::R_STOP && mode.stp && rbit == 4'h0)
    || (rst_q == uart_async_pkg::R_PAR && !mode.stp)
    || (rst_q == uart_async_pkg::R_DATA && rbit == nbits - 4'h1
      && !mode.pe && !mode.stp));

  always_ff @(posedge clk) begin
    if (rst || !c1.re || !async_mode) begin
      rst_q <= uart_async_pkg::R_IDLE;
      rx_prev <= 1'b1;
      rcnt <= 4'h0;
      rbit <= 4'h0;
      rsh <= 9'h000;
      racc <= 1'b0;
      rbad <= 1'b0;
      rfer <= 1'b0;
      rovr <= 1'b0;
    end else begin
      rx_prev <= rx_level;
      if (rst_q != uart_async_pkg::R_IDLE && tick) begin
        rcnt <= rcnt + 4'h1;
      end
      if (ovr_pt && rx_full) begin
        rovr <= 1'b1;
      end
      unique case (rst_q)
        uart_async_pkg::R_IDLE: if (rx_prev && !rx_level) begin
          rcnt <= 4'h0;
          rbit <= 4'h0;
          racc <= 1'b0;
          rbad <= 1'b0;
          rfer <= 1'b0;
          rovr <= 1'b0;
          rst_q <= uart_async_pkg::R_START;
        end
        uart_async_pkg::R_START: begin
          if (sample && rx_level) begin
            rst_q <= uart_async_pkg::R_IDLE;
          end else if (rend) begin
            rst_q <= uart_async_pkg::R_DATA;
          end
        end
        uart_async_pkg::R_DATA: begin
          if (sample) begin
            rsh <= {rx_level, rsh[8:1]};
            racc <= racc ^ rx_level;
          end
          if (rend) begin
            if (rbit == nbits - 4'h1) begin
              rbit <= 4'h0;
              rst_q <= mode.pe ? uart_async_pkg::R_PAR
                : uart_async_pkg::R_STOP;
            end else begin
              rbit <= rbit + 4'h1;
            end
          end
        end
        uart_async_pkg::R_PAR: begin
          if (sample) begin
            rbad <= racc ^ rx_level ^ !mode.even;
          end
          if (rend) begin
            rst_q <= uart_async_pkg::R_STOP;
          end
        end
        uart_async_pkg::R_STOP: begin
          if (sample && !rx_level) begin
            rfer <= 1'b1;
          end
          if (done) begin
            rst_q <= uart_async_pkg::R_IDLE;
          end else if (rend) begin
            rbit <= rbit + 4'h1;
          end
        end
        default: rst_q <= uart_async_pkg::R_IDLE; // illegal code
      endcase
    end
  end

  // receive buffer, complete flag and errors; set wins over read
  always_ff @(posedge clk) begin
    if (rst) begin
      rbuf <= 9'h000;
      rx_full <= 1'b0;
      framing_flag <= 1'b0;
      parity_flag <= 1'b0;
    end else if (done && !rovr && !(ovr_pt && rx_full)) begin
      rbuf <= rx_al;
      rx_full <= 1'b1;
      framing_flag <= rfer || !rx_level;
      parity_flag <= rbad && mode.pe;
    end else if (rx_rd) begin
      rx_full <= 1'b0;
    end
  end

  // overrun stays until reception is disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr <= 1'b0;
    end else if (ovr_pt && rx_full && c1.re) begin
      ovr <= 1'b1;
    end else if (!c1.re) begin
      ovr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_stb) begin
      unique case (addr)
        uart_async_pkg::OFS_RXBUF: begin
          next_rdata[8:0] = rx_word;
          next_rdata[uart_async_pkg::RX_OVR_BIT] = ovr;
          next_rdata[uart_async_pkg::RX_FRM_BIT] = framing_flag;
          next_rdata[uart_async_pkg::RX_PAR_BIT] = parity_flag;
          next_rdata[uart_async_pkg::RX_SUM_BIT] = ovr | framing_flag
            | parity_flag;
        end
        uart_async_pkg::OFS_MODE: next_rdata[7:0] = mode;
        uart_async_pkg::OFS_CTRL0: next_rdata[7:0] = {c0[7:4],
          tst == uart_async_pkg::T_IDLE, c0[2:0]};
        uart_async_pkg::OFS_CTRL1: next_rdata[7:0] = {c1[7:4], rx_full,
          c1[2], tbuf_empty, c1[0]};
        uart_async_pkg::OFS_SHARED:
          next_rdata[uart_async_pkg::SHARED_SPLIT_BIT] = split;
        default: next_rdata = 16'h0000; // write-only or unmapped
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b1;
      handshake_out <= 1'b1;
      handshake_oe <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      rdata <= next_rdata;
      serial_out_pin <= tx_line ^ mode.pol;
      // open drain releases the line for a high level
      serial_out_oe <= !c0.od || !(tx_line ^ mode.pol);
      handshake_out <= !(c1.re && !rx_full);
      handshake_oe <= !c0.dis && c0.dir;
      tx_irq <= (tx_go && !c1.irs)
        || (tst == uart_async_pkg::T_STOP && tend
          && tbit[0] == mode.stp && c1.irs);
      rx_irq <= done && !rovr && !(ovr_pt && rx_full);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_sum;
    @(posedge clk) disable iff (rst)
    rx_rd |=> rdata[15] == (rdata[14] | rdata[13] | rdata[12]);
  endproperty
  a_sum: assert property (p_sum)
    else $error("summary flag wrong");

  property p_tx_start;
    @(posedge clk) disable iff (rst)
    tst == uart_async_pkg::T_IDLE ##1 tst == uart_async_pkg::T_START
      |-> $past(c1.te) && $past(cts_ok) && !$past(tbuf_empty);
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("bad tx start");

  property p_tx_irq_load;
    @(posedge clk) disable iff (rst)
    tx_go && !c1.irs |=> tx_irq && tbuf_empty;
  endproperty
  a_tx_irq_load: assert property (p_tx_irq_load)
    else $error("no tx irq");

  property p_rx_irq;
    @(posedge clk) disable iff (rst)
    rx_irq |-> rx_full && $past(rst_q == uart_async_pkg::R_STOP);
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("rx irq unpaired");

  property p_idle_high;
    @(posedge clk) disable iff (rst)
    $past(tst == uart_async_pkg::T_IDLE) && !$past(c0.od)
      |-> serial_out_pin == !$past(mode.pol) && serial_out_oe;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("idle not high");

  property p_hs_dir;
    @(posedge clk) disable iff (rst)
    !c0.dis && c0.dir ##1 !c0.dis && c0.dir |-> handshake_oe;
  endproperty
  a_hs_dir: assert property (p_hs_dir)
    else $error("rts not driven");

  property p_rx_start;
    @(posedge clk) disable iff (rst)
    rst_q == uart_async_pkg::R_IDLE ##1 rst_q == uart_async_pkg::R_START
      |-> $past(c1.re) && !$past(rx_level);
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("bad rx start");

  property p_ovr_quiet;
    @(posedge clk) disable iff (rst)
    ovr_pt && rx_full && c1.re |=> ovr ##1 !rx_irq [*3];
  endproperty
  a_ovr_quiet: assert property (p_ovr_quiet)
    else $error("overrun irq");

endmodule // uart_async_channel

// *** dv/serial_peer.sv ***
// Purpose: remote serial peer that sends and captures frames
// Assumes: sixteen clk per bit, line idles high
// Notes: frame bits are given start bit first, in the low end
`timescale 1ns/1ns
module serial_peer (
  input wire logic clk,
  input wire logic rx_line,
  output logic tx_line
);
  // ------------------------------------------------------------
  // frame driver and capture
  // ------------------------------------------------------------
  initial tx_line = 1'b1; // idle high between frames
  // drive n bits, sixteen clocks each, then idle high
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_line <= bits[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    tx_line <= 1'b1;
  endtask
  // sample each bit mid-period after the falling edge
  task automatic grab(output logic [11:0] bits, input int n);
    bits = '0;
    @(negedge rx_line);
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = rx_line;
      repeat (16) @(posedge clk);
    end
  endtask
endmodule // serial_peer

// *** dv/tb_top.sv ***
// Purpose: register-level tests of the async serial channel
// Assumes: divider 0, undivided source, so sixteen clk per bit
// Notes: 8-bit even parity, one stop; rts selected on own pin
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic serial_in_pin, serial_out_pin, handshake_out, tx_irq, rx_irq;
  logic serial_out_oe, handshake_oe;
  logic [11:0] frame;
  int errors = 0, check_count = 0, tx_irqs = 0, rx_irqs = 0, n1 = 0;
  always #2 clk = ~clk; // 250 MHz
  uart_async_channel dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .serial_in_pin(serial_in_pin), .serial_clock_pin(1'b0),
    .handshake_in(1'b0), .peer_handshake_in(1'b1),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .handshake_out(handshake_out), .handshake_oe(handshake_oe),
    .tx_irq(tx_irq),
    .rx_irq(rx_irq));
  serial_peer peer (.clk(clk), .rx_line(serial_out_pin),
    .tx_line(serial_in_pin));
  // count request pulses
  always @(posedge clk) begin
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
  end
  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  // receive one frame, check request, rts and buffer word
  task automatic rx_case(input logic [11:0] bits, input logic [15:0] exp);
    int n0;
    n0 = rx_irqs;
    peer.send(bits, 11);
    repeat (4) @(posedge clk);
    chk(16'(rx_irqs - n0), 16'h0001);
    chk({15'h0000, handshake_out}, 16'h0001);
    rd(uart_async_pkg::OFS_RXBUF, v);
    chk(v, exp);
    // rts follows the cleared flag one registered cycle later
    repeat (2) @(posedge clk);
    chk({15'h0000, handshake_out}, 16'h0000);
    $display("test rx %h done", exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(uart_async_pkg::OFS_MODE, v);
    chk(v, 16'h0000);
    rd(uart_async_pkg::OFS_CTRL1, v);
    chk({15'h0000, v[1]}, 16'h0001);
    wr(uart_async_pkg::OFS_MODE, 16'h0065);
    wr(uart_async_pkg::OFS_CTRL0, 16'h0004);
    wr(uart_async_pkg::OFS_CTRL1, 16'h0005);
    chk({15'h0000, serial_out_pin}, 16'h0001);
    chk({15'h0000, serial_out_oe}, 16'h0001);
    chk({15'h0000, handshake_oe}, 16'h0001);
    $display("test setup done");
    fork
      peer.grab(frame, 11);
      wr(uart_async_pkg::OFS_TXBUF, 16'h00A5);
    join
    chk({4'h0, frame}, {6'h01, 1'b0, 8'hA5, 1'b0});
    chk(16'(tx_irqs), 16'h0001);
    rd(uart_async_pkg::OFS_CTRL0, v);
    chk({15'h0000, v[3]}, 16'h0001);
    $display("test tx done");
    rx_case({1'b0, 1'b1, 1'b0, 8'h3C, 1'b0}, 16'h003C);
    rx_case({1'b0, 1'b1, 1'b1, 8'h3C, 1'b0}, 16'hC03C);
    rx_case({1'b0, 1'b0, 1'b0, 8'h3C, 1'b0}, 16'hA03C);
    wr(uart_async_pkg::OFS_CTRL1, 16'h0045);
    rx_case({1'b0, 1'b1, 1'b0, 8'hC3, 1'b0}, 16'h003C);
    // second frame while the first is unread: overrun, no request
    peer.send({1'b0, 1'b1, 1'b0, 8'hC3, 1'b0}, 11);
    n1 = rx_irqs;
    peer.send({1'b0, 1'b1, 1'b0, 8'hC3, 1'b0}, 11);
    repeat (4) @(posedge clk);
    chk(16'(rx_irqs - n1), 16'h0000);
    rd(uart_async_pkg::OFS_RXBUF, v);
    chk(v, 16'h903C);
    $display("test overrun done");
    // receive off clears overrun; tx request moves to frame end
    wr(uart_async_pkg::OFS_CTRL1, 16'h0011);
    rd(uart_async_pkg::OFS_RXBUF, v);
    chk({15'h0000, v[12]}, 16'h0000);
    fork
      peer.grab(frame, 11);
      begin
        wr(uart_async_pkg::OFS_TXBUF, 16'h005A);
        repeat (4) @(posedge clk);
        chk(16'(tx_irqs), 16'h0001);
      end
    join
    chk(16'(tx_irqs), 16'h0002);
    chk({4'h0, frame}, {6'h01, 1'b0, 8'h5A, 1'b0});
    $display("test tx finish request done");
    give_verdict;
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule // tb_top
